// file: src/csp_defs.svh
// Offsets, field positions, reset values and counts of the config serial port
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH
`define CSP_ADDR_W 6
`define CSP_DATA_W 8
`define CSP_HDR_BITS 8
`define CSP_HDR_RNW 7
`define CSP_HDR_ADDR_HI 6
`define CSP_HDR_ADDR_LO 1
`define CSP_OFF_SOCB 6'h19
`define CSP_OFF_RDBK 6'h3A
`define CSP_OFF_TRIS 6'h3B
`define CSP_OFF_REV 6'h3F
`define CSP_BIT_4WIRE 7
`define CSP_BIT_RDBK 3
`define CSP_BIT_TRIS 3
`define CSP_SWRST_VAL 8'h99
`define CSP_REG_RESET 8'h00
`define CSP_REV_VAL 8'h5A
`endif

// file: src/csp_pkg.sv
// Types shared by the config serial port design files
package csp_pkg;
  // Link-side shifter states, Gray along the write path; CSP_HDR to CSP_READ flips both bits
  typedef enum logic [1:0] {
    CSP_IDLE = 2'b00,
    CSP_HDR = 2'b01,
    CSP_DATA = 2'b11,
    CSP_READ = 2'b10
  } csp_state_t;
  // Register write request crossing to the system domain
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } csp_wr_t;
  // Live mode bits the link side needs
  typedef struct packed {
    logic fourWire;
    logic readback;
    logic tristateB;
  } csp_mode_t;
endpackage : csp_pkg

// file: src/csp_port.sv
// Config serial port: link-side shifter and system-side register file
`include "csp_defs.svh"
module csp_port
  import csp_pkg::*;
#(
  parameter int ADDR_W = `CSP_ADDR_W,
  parameter int DATA_W = `CSP_DATA_W
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Link clock and select from the host
  input wire logic port_serial_clock,
  input wire logic port_select_low,
  // Bidirectional data line, enable low drives
  input wire logic portBidirIn,
  output logic portBidirOut,
  output logic portBidirOe_n,
  // Secondary serial output, enable low drives
  output logic secondarySerialOut,
  output logic secondarySerialOe_n,
  // Live configuration for the rest of the chip
  output logic [DATA_W-1:0] serialOutCtrlB,
  output logic chipReset
);
  localparam int HB = `CSP_HDR_BITS;

  // Link-domain state
  csp_state_t state_r;
  logic [2:0] bitCnt_r;
  logic [DATA_W-1:0] shift_r;
  logic [ADDR_W-1:0] addr_r;
  logic wrTog_r;
  csp_wr_t wrHold_r;
  logic [DATA_W-1:0] txShift_r;
  logic drive_r;
  logic txBit_r;
  // System-domain state, then the link-side mode bits, read data and select signals
  logic [2:0] togSync_r;
  logic swReset_r;
  logic resetAll;
  logic sysWrEn;
  csp_wr_t sysWr;
  logic [DATA_W-1:0] rdData;
  logic [DATA_W-1:0] rdCap_r;
  csp_mode_t mode_r;
  csp_mode_t modeLink;
  logic [DATA_W-1:0] rdLink;
  logic linkReset;
  logic selLow;

  // Pick the address field of a header; the read flag is taken straight from shift_r
  function automatic logic [ADDR_W-1:0] hdrAddr(input logic [7:0] h);
    hdrAddr = h[`CSP_HDR_ADDR_HI:`CSP_HDR_ADDR_LO];
  endfunction : hdrAddr

  assign selLow = ~port_select_low;
  // Select high holds the link logic idle; no clock needed to abort
  assign linkReset = port_select_low;

  // Mode bits and read data cross into the link domain
  csp_sync #(.W(3)) uModeSync (
    .clk(port_serial_clock),
    .reset(1'b0),
    .d({mode_r.fourWire, mode_r.readback, mode_r.tristateB}),
    .q({modeLink.fourWire, modeLink.readback, modeLink.tristateB})
  );
  // Readback word settles two system clocks after the header ends, before the first falling-edge launch
  assign rdLink = rdCap_r;

  // Header and data shifter on rising clock, MSB first
  always_ff @(posedge port_serial_clock or posedge linkReset) begin
    if (linkReset) begin
      state_r <= CSP_IDLE;
      bitCnt_r <= 3'h0;
      shift_r <= '0;
      addr_r <= '0;
    end else begin
      unique case (state_r)
        CSP_IDLE, CSP_HDR: begin
          shift_r <= {shift_r[DATA_W-2:0], portBidirIn};
          bitCnt_r <= bitCnt_r + 3'h1;
          state_r <= CSP_HDR;
          if (bitCnt_r == 3'(HB - 1)) begin
            addr_r <= hdrAddr({shift_r[6:0], portBidirIn});
            state_r <= shift_r[`CSP_HDR_RNW - 1] ? CSP_READ : CSP_DATA;
          end
        end
        CSP_DATA: begin
          shift_r <= {shift_r[DATA_W-2:0], portBidirIn};
          bitCnt_r <= bitCnt_r + 3'h1;
          if (bitCnt_r == 3'(HB - 1)) begin
            addr_r <= addr_r + ADDR_W'(1);
          end
        end
        CSP_READ: begin
          bitCnt_r <= bitCnt_r + 3'h1;
        end
      endcase
    end
  end

  // Completed write byte handed over by toggle; partial bytes never post
  always_ff @(posedge port_serial_clock or posedge reset) begin
    if (reset) begin
      wrTog_r <= 1'b0;
      wrHold_r <= '0;
    end else if (!linkReset && state_r == CSP_DATA &&
                 bitCnt_r == 3'(HB - 1)) begin
      wrHold_r <= '{addr: addr_r, data: {shift_r[6:0], portBidirIn}};
      wrTog_r <= ~wrTog_r;
    end
  end

  // Read data launched on falling edges, MSB first
  always_ff @(negedge port_serial_clock or posedge linkReset) begin
    if (linkReset) begin
      drive_r <= 1'b0;
      txShift_r <= '0;
      txBit_r <= 1'b0;
    end else if (state_r == CSP_READ) begin
      if (!drive_r && bitCnt_r == 3'h0) begin
        drive_r <= 1'b1;
        txBit_r <= rdLink[DATA_W-1];
        txShift_r <= {rdLink[DATA_W-2:0], 1'b0};
      end else if (drive_r) begin
        txBit_r <= txShift_r[DATA_W-1];
        txShift_r <= {txShift_r[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Three-wire reads need readback; four-wire also uses secondary pin
  assign portBidirOut = txBit_r;
  assign portBidirOe_n = ~(drive_r & modeLink.readback & selLow);
  assign secondarySerialOut = (drive_r & modeLink.fourWire & selLow)
                              ? txBit_r : 1'b0;
  assign secondarySerialOe_n = mode_r.tristateB;

  // Write toggle synchronised into the system domain
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      togSync_r <= 3'h0;
    end else begin
      togSync_r <= {togSync_r[1:0], wrTog_r};
    end
  end
  assign sysWrEn = togSync_r[2] ^ togSync_r[1];
  // Held word is stable for many system clocks after the toggle
  assign sysWr = wrHold_r;

  // Revision write of the magic value resets like power-on
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      swReset_r <= 1'b0;
    end else begin
      swReset_r <= sysWrEn && sysWr.addr == `CSP_OFF_REV &&
                   sysWr.data == `CSP_SWRST_VAL;
    end
  end
  assign resetAll = reset | swReset_r;
  assign chipReset = resetAll;

  // Register memory; revision address is never written
  csp_regfile #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) uRegs (
    .clk_sys(clk_sys),
    .reset(resetAll),
    .wrEn(sysWrEn && sysWr.addr != `CSP_OFF_REV),
    .wrAddr(sysWr.addr),
    .wrData(sysWr.data),
    .rdAddr(addr_r),
    .rdData(rdData)
  );

  // Readback source; revision reads a fixed arbitrary code
  always_ff @(posedge clk_sys) begin
    if (resetAll) begin
      rdCap_r <= '0;
    end else begin
      rdCap_r <= (addr_r == `CSP_OFF_REV) ? DATA_W'(`CSP_REV_VAL) : rdData;
    end
  end

  // Mode bits tracked from writes; multi-byte commit is per-byte here
  always_ff @(posedge clk_sys) begin
    if (resetAll) begin
      mode_r <= '0;
    end else if (sysWrEn) begin
      if (sysWr.addr == `CSP_OFF_SOCB) begin
        mode_r.fourWire <= sysWr.data[`CSP_BIT_4WIRE];
      end
      if (sysWr.addr == `CSP_OFF_RDBK) begin
        mode_r.readback <= sysWr.data[`CSP_BIT_RDBK] | mode_r.fourWire;
      end
      if (sysWr.addr == `CSP_OFF_TRIS) begin
        mode_r.tristateB <= sysWr.data[`CSP_BIT_TRIS];
      end
      if (sysWr.addr == `CSP_OFF_SOCB && sysWr.data[`CSP_BIT_4WIRE]) begin
        mode_r.readback <= 1'b1;
      end
    end
  end

  // Serial output control B as seen by the rest of the chip
  always_ff @(posedge clk_sys) begin
    if (resetAll) begin
      serialOutCtrlB <= '0;
    end else if (sysWrEn && sysWr.addr == `CSP_OFF_SOCB) begin
      serialOutCtrlB <= sysWr.data;
    end
  end
endmodule : csp_port

// file: src/csp_regfile.sv
// Configuration register memory with registered read data
module csp_regfile
  import csp_pkg::*;
#(
  parameter int ADDR_W = 6,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Write port
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  // Read port
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem_r [2**ADDR_W];

  // Storage, cleared on reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem_r[i] <= DATA_W'(`CSP_REG_RESET);
      end
    end else if (wrEn) begin
      mem_r[wrAddr] <= wrData;
    end
  end

  // Registered read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData <= DATA_W'(`CSP_REG_RESET);
    end else begin
      rdData <= mem_r[rdAddr];
    end
  end
endmodule : csp_regfile

// file: src/csp_sync.sv
// Two-flop synchroniser for levels
module csp_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic reset,
  // Level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First flop feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : csp_sync

// file: verif/config_serial_port_tb.sv
// Bench for the config serial port
`include "csp_defs.svh"
module config_serial_port_tb import csp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic rstSeen = 1'b0;
  logic sclk, sel, line, bOut, bOe_n, sOut, sOe_n, chipRst;
  logic [7:0] ctrlB, q, q2;
  logic [7:0] mem [64];
  logic [5:0] a;
  logic [15:0] d;
  int seed = 67016;
  int miscompares = 0;
  int checked = 0;
  int n;
  // Device and host
  csp_port dut (.clk_sys(clk_sys), .reset(reset), .port_serial_clock(sclk),
    .port_select_low(sel), .portBidirIn(line), .portBidirOut(bOut),
    .portBidirOe_n(bOe_n), .secondarySerialOut(sOut),
    .secondarySerialOe_n(sOe_n), .serialOutCtrlB(ctrlB),
    .chipReset(chipRst));
  csp_host_model host (.port_serial_clock(sclk), .port_select_low(sel),
    .lineLvl(line), .portBidirOut(bOut), .portBidirOe_n(bOe_n),
    .secondarySerialOut(sOut));
  // System clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Watchdog
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
  // Notes a soft reset pulse
  always @(posedge clk_sys) begin
    if (chipRst === 1'b1 && !reset) begin
      rstSeen <= 1'b1;
    end
  end
  function automatic logic [7:0] expRd(input logic [5:0] ad);
    return ad == `CSP_OFF_REV ? `CSP_REV_VAL : mem[ad];
  endfunction : expRd
  task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One frame, started off the clock edge
  task automatic go(input logic r, input logic [5:0] ad,
      input logic [15:0] dv, input int nb);
    @(posedge clk_sys);
    #7;
    host.frame(r, ad, dv, nb, q, q2);
    repeat (10) @(posedge clk_sys);
    #1;
  endtask : go
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    foreach (mem[k]) mem[k] = 8'h00;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("idle", 8'h01, {6'h00, sOe_n, bOe_n});
    go(1'b1, 6'h05, 16'h0000, 8);
    chk("drove", 8'h00, {7'h00, host.drove});
    go(1'b0, `CSP_OFF_RDBK, 16'h0800, 8);
    for (int i = 0; i < 8; i++) begin
      a = 6'($unsigned($random(seed)) % 23);
      d = 16'($random(seed));
      n = (i % 2) ? 9 + i % 7 : 16;
      go(1'b0, a, d, n);
      mem[a] = d[15:8];
      if (n == 16) mem[a+6'h01] = d[7:0];
      go(1'b1, a, 16'h0000, 8);
      chk("read", expRd(a), q);
      go(1'b1, a + 6'h01, 16'h0000, 8);
      chk("next", expRd(a + 6'h01), q);
    end
    go(1'b0, `CSP_OFF_SOCB, 16'h8000, 8);
    chk("ctrlB", 8'h80, ctrlB);
    go(1'b1, a, 16'h0000, 8);
    chk("secRead", expRd(a), q2);
    go(1'b0, `CSP_OFF_SOCB, 16'h0000, 6);
    chk("ctrlB", 8'h80, ctrlB);
    go(1'b0, `CSP_OFF_TRIS, 16'h0800, 8);
    chk("tris", 8'h01, {7'h00, sOe_n});
    go(1'b0, `CSP_OFF_REV, 16'h1200, 8);
    go(1'b1, `CSP_OFF_REV, 16'h0000, 8);
    chk("rev", expRd(`CSP_OFF_REV), q);
    go(1'b0, `CSP_OFF_REV, 16'h9900, 8);
    chk("softRst", 8'h01, {7'h00, rstSeen});
    chk("cleared", 8'h00, {ctrlB[7:1], sOe_n});
    stop_test();
  end
endmodule : config_serial_port_tb
bind csp_port csp_port_assertions u_chk (.clk_sys(clk_sys), .reset(reset),
  .port_select_low(port_select_low), .portBidirOut(portBidirOut),
  .portBidirOe_n(portBidirOe_n), .secondarySerialOut(secondarySerialOut),
  .secondarySerialOe_n(secondarySerialOe_n),
  .serialOutCtrlB(serialOutCtrlB), .chipReset(chipReset));

// file: verif/csp_host_model.sv
// Behavioural host acting as port master
module csp_host_model (
  // Host-driven link pins
  output logic port_serial_clock,
  output logic port_select_low,
  // Resolved data line and device pins
  output logic lineLvl,
  input wire logic portBidirOut,
  input wire logic portBidirOe_n,
  input wire logic secondarySerialOut
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hostEn = 1'b1;
  logic hostBit = 1'b0;
  logic junk = 1'b0;
  logic drove;
  // Released line toggles so stale bits never pass
  assign lineLvl = !portBidirOe_n ? portBidirOut : hostEn ? hostBit : junk;
  always #40 junk = ~junk;
  // Clock idles low outside frames, select idles high
  initial begin
    port_serial_clock = 1'b0;
    port_select_low = 1'b1;
  end
  // One bit: set data, rise to sample, fall
  task automatic sh(input logic b, input logic k, output logic s,
      output logic s2);
    hostBit = b;
    #80 port_serial_clock = 1'b1;
    s = lineLvl;
    s2 = secondarySerialOut;
    hostEn = k;
    drove |= !portBidirOe_n;
    #80 port_serial_clock = 1'b0;
  endtask : sh
  // Header then nb data bits, MSB first
  task automatic frame(input logic rd, input logic [5:0] a,
      input logic [15:0] d, input int nb, output logic [7:0] q,
      output logic [7:0] q2);
    logic [7:0] hdr;
    logic s;
    logic s2;
    hdr = {rd, a, 1'b0};
    drove = 1'b0;
    port_select_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sh(hdr[i], !(rd && i == 0), s, s2);
    end
    for (int i = 0; i < nb; i++) begin
      sh(d[15-i], !rd, s, s2);
      q = {q[6:0], s};
      q2 = {q2[6:0], s2};
    end
    #80 port_select_low = 1'b1;
    hostEn = 1'b1;
  endtask : frame
endmodule : csp_host_model

// file: verif/csp_port_assertions.sv
// Pin-level checks of the config serial port
module csp_port_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Watched pins
  input wire logic port_select_low,
  input wire logic portBidirOut,
  input wire logic portBidirOe_n,
  input wire logic secondarySerialOut,
  input wire logic secondarySerialOe_n,
  input wire logic [7:0] serialOutCtrlB,
  input wire logic chipReset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_reset_pins: assert property ($fell(reset) |-> portBidirOe_n &&
    !secondarySerialOe_n && !secondarySerialOut) else $error("reset pins");
  a_sel_release: assert property (port_select_low[*2] |-> portBidirOe_n)
    else $error("line held");
  a_sec_idle: assert property (port_select_low[*2] |-> !secondarySerialOut)
    else $error("sec not low");
  a_sec_copy: assert property (!portBidirOe_n && serialOutCtrlB[7] &&
    !secondarySerialOe_n |-> secondarySerialOut == portBidirOut)
    else $error("sec copy");
  a_hdr_first: assert property ($fell(portBidirOe_n) |->
    !$past(port_select_low, 30)) else $error("early drive");
  a_regs_idle: assert property (port_select_low[*8] |->
    $stable(serialOutCtrlB)) else $error("idle change");
  a_rst_pulse: assert property ($rose(chipReset) |-> ##[1:2] !chipReset)
    else $error("long pulse");
  a_rst_clears: assert property (chipReset |-> ##[0:2]
    serialOutCtrlB == 8'h00) else $error("not cleared");
endmodule : csp_port_assertions
